// *** rtl/fpe_defines.svh ***
// Offsets, field positions, reset values and address ranges of the flash control block
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

// Register offsets on the plain register port
`define FPE_OFS_MODE        4'h0
`define FPE_OFS_FAULT       4'h1
`define FPE_OFS_AREA        4'h2
`define FPE_OFS_GATE        4'h3

// Mode control fields
`define FPE_MC_RSVD         7
`define FPE_MC_UNLOCK       6
`define FPE_MC_ERASE_SETUP  5
`define FPE_MC_PROG_SETUP   4
`define FPE_MC_ERASE_CHECK  3
`define FPE_MC_PROG_CHECK   2
`define FPE_MC_EGO          1
`define FPE_MC_PGO          0

// Fault status and access gate fields
`define FPE_FS_FAULT        7
`define FPE_GATE_BIT        7

// Reset values
`define FPE_MODE_RESET      8'h00
`define FPE_FAULT_RESET     1'b0
`define FPE_AREA_RESET      5'h00
`define FPE_GATE_RESET      1'b0

// Erase area address ranges, small areas 0..3 then the large area
`define FPE_AREA0_BASE      15'h0000
`define FPE_AREA0_LIMIT     15'h03FF
`define FPE_AREA1_BASE      15'h0400
`define FPE_AREA1_LIMIT     15'h07FF
`define FPE_AREA2_BASE      15'h0800
`define FPE_AREA2_LIMIT     15'h0BFF
`define FPE_AREA3_BASE      15'h0C00
`define FPE_AREA3_LIMIT     15'h0FFF
`define FPE_AREA4_BASE      15'h1000
`define FPE_AREA4_LIMIT     15'h7FFF

`endif

// *** rtl/fpe_pkg.sv ***
// Types shared by the flash program and erase control block
package fpe_pkg;

    // Register selected by the current bus address
    typedef enum logic [2:0] {
        SEL_MODE,
        SEL_FAULT,
        SEL_AREA,
        SEL_GATE,
        SEL_NONE
    } fpe_sel_t;

    // Whole state of the control block
    typedef struct packed {
        logic [7:0] mode;
        logic [4:0] area;
        logic       fault;
        logic       gate;
        logic [7:0] rdata;
        logic       prog_mode;
        logic       erase_mode;
        logic       area_hit;
    } fpe_state_t;

endpackage

// *** rtl/fpe_area_match.sv ***
// Address range match for one erase area
`timescale 1ns/1ns
`default_nettype none

module fpe_area_match #(
    parameter logic [14:0] BASE  = 15'h0000,
    parameter logic [14:0] LIMIT = 15'h03FF
) (
    // Flash array address
    input  wire logic [14:0] addr,
    // Address lies inside the area
    output logic             hit
);

    // Inclusive range compare
    assign hit = (addr >= BASE) && (addr <= LIMIT);

endmodule

`default_nettype wire

// *** rtl/fpe_flash_ctrl.sv ***
// Flash program, erase and verify mode control with erase area select
//
// Operation
// R1 - Mode control bit 7 reads zero
// R2 - Program and erase need unlock bit set
// R3 - Locked writes cannot set other bits
// R4 - Erase setup bit enters, leaves setup state
// R5 - Software sets erase setup before erase-go
// R6 - Program setup bit enters, leaves setup state
// R7 - Software sets program setup before program-go
// R8 - Erase check bit controls erase-verify mode
// R9 - Program check bit controls program-verify mode
// R10 - Erase mode needs unlock, setup and go
// R11 - Program mode needs unlock, setup and go
// R12 - Software never writes fault status register
// R13 - Fault bit holds flash in error protection
// R14 - Fault status bits 6..0 read zero
// R15 - Area select zero while unlock is clear
// R16 - Several area bits written clears all
// R17 - Software selects at most one area
// R18 - Bit 4 selects large area 1000..7FFF
// R19 - Bit 3 selects area 0C00..0FFF
// R20 - Bit 2 selects area 0800..0BFF
// R21 - Bit 1 selects area 0400..07FF
// R22 - Bit 0 selects area 0000..03FF
// R23 - Access gate bit blocks control registers
`include "fpe_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module fpe_flash_ctrl #(
    parameter int AREAS = 5
) (
    // Clock, reset and clock enable
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Flash array side
    input  wire logic [14:0] ARRAY_ADDR,
    input  wire logic        ARRAY_FAULT,
    // Mode outputs to the flash array
    output logic             PROG_SETUP,
    output logic             ERASE_SETUP,
    output logic             PROG_VERIFY,
    output logic             ERASE_VERIFY,
    output logic             PROG_MODE,
    output logic             ERASE_MODE,
    output logic      [4:0]  ERASE_AREA,
    output logic             AREA_HIT,
    output logic             ERROR_PROTECT
);

    // Per area range bounds
    localparam logic [14:0] AREA_BASE [AREAS] = '{
        `FPE_AREA0_BASE, `FPE_AREA1_BASE, `FPE_AREA2_BASE,
        `FPE_AREA3_BASE, `FPE_AREA4_BASE
    };
    localparam logic [14:0] AREA_LIMIT [AREAS] = '{
        `FPE_AREA0_LIMIT, `FPE_AREA1_LIMIT, `FPE_AREA2_LIMIT,
        `FPE_AREA3_LIMIT, `FPE_AREA4_LIMIT
    };

    // Reset image of the state
    localparam fpe_pkg::fpe_state_t ST_RESET = '{
        mode:       `FPE_MODE_RESET,
        area:       `FPE_AREA_RESET,
        fault:      `FPE_FAULT_RESET,
        gate:       `FPE_GATE_RESET,
        rdata:      8'h00,
        prog_mode:  1'b0,
        erase_mode: 1'b0,
        area_hit:   1'b0
    };

    fpe_pkg::fpe_state_t s_q;
    fpe_pkg::fpe_state_t s_d;
    fpe_pkg::fpe_sel_t   sel;
    logic [AREAS-1:0]    range_hit;
    logic                access_ok;
    logic                unlock_d;
    logic                multi_sel;

    // One range matcher per erase area
    genvar gi;
    generate
        for (gi = 0; gi < AREAS; gi++) begin : g_area
            fpe_area_match #(
                .BASE  (AREA_BASE[gi]),
                .LIMIT (AREA_LIMIT[gi])
            ) u_match (
                .addr (ARRAY_ADDR),
                .hit  (range_hit[gi])  // [R18] [R19] [R20] [R21] [R22]
            );
        end
    endgenerate

    // Address decode
    always_comb begin
        unique case (ADDR)
            `FPE_OFS_MODE:  sel = fpe_pkg::SEL_MODE;
            `FPE_OFS_FAULT: sel = fpe_pkg::SEL_FAULT;
            `FPE_OFS_AREA:  sel = fpe_pkg::SEL_AREA;
            `FPE_OFS_GATE:  sel = fpe_pkg::SEL_GATE;
            default:        sel = fpe_pkg::SEL_NONE;
        endcase
    end

    // Control registers reachable only with the gate open
    assign access_ok = s_q.gate || (sel == fpe_pkg::SEL_GATE);  // [R23]
    assign multi_sel = $countones(WDATA[4:0]) > 1;

    // Next state
    always_comb begin
        s_d      = s_q;
        unlock_d = s_q.mode[`FPE_MC_UNLOCK];
        // Access gate register is always reachable
        if (WR && sel == fpe_pkg::SEL_GATE) begin
            s_d.gate = WDATA[`FPE_GATE_BIT];
        end
        // Mode control write, other bits stick only when unlocked
        if (WR && access_ok && sel == fpe_pkg::SEL_MODE) begin
            unlock_d = WDATA[`FPE_MC_UNLOCK];
            if (unlock_d) begin
                s_d.mode = {1'b0, WDATA[6:0]};  // [R1] [R4] [R6] [R8] [R9]
            end else begin
                s_d.mode = 8'h00;  // [R3]
            end
        end
        // Area select write, ignored while locked
        if (WR && access_ok && sel == fpe_pkg::SEL_AREA && s_q.mode[`FPE_MC_UNLOCK]) begin
            if (multi_sel) begin
                s_d.area = 5'h00;  // [R16]
            end else begin
                s_d.area = WDATA[4:0];
            end
        end
        // Area select held clear while locked
        if (!unlock_d) begin
            s_d.area = 5'h00;  // [R15] [R3]
        end
        // Array fault during an active pulse latches until reset
        if (ARRAY_FAULT && (s_q.prog_mode || s_q.erase_mode)) begin
            s_d.fault = 1'b1;
        end
        // Error protection drops both go bits
        if (s_d.fault) begin
            s_d.mode[`FPE_MC_EGO] = 1'b0;  // [R13]
            s_d.mode[`FPE_MC_PGO] = 1'b0;  // [R13]
        end
        // Active modes need unlock, matching setup and go
        s_d.erase_mode = s_d.mode[`FPE_MC_UNLOCK] && s_d.mode[`FPE_MC_ERASE_SETUP]
                         && s_d.mode[`FPE_MC_EGO] && !s_d.fault;  // [R2] [R10]
        s_d.prog_mode  = s_d.mode[`FPE_MC_UNLOCK] && s_d.mode[`FPE_MC_PROG_SETUP]
                         && s_d.mode[`FPE_MC_PGO] && !s_d.fault;  // [R2] [R11]
        // Array address falls in the selected erase area
        s_d.area_hit = |(range_hit & s_d.area);
        // Read data, present only in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (RD && access_ok) begin
            unique case (sel)
                fpe_pkg::SEL_MODE:  s_d.rdata = {1'b0, s_q.mode[6:0]};  // [R1]
                fpe_pkg::SEL_FAULT: s_d.rdata = {s_q.fault, 7'h00};  // [R14] [R12]
                fpe_pkg::SEL_AREA:  s_d.rdata = {3'h0, s_q.area};
                fpe_pkg::SEL_GATE:  s_d.rdata = {s_q.gate, 7'h00};
                fpe_pkg::SEL_NONE:  s_d.rdata = 8'h00;
            endcase
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_q <= ST_RESET;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign RDATA         = s_q.rdata;
    assign PROG_SETUP    = s_q.mode[`FPE_MC_PROG_SETUP];
    assign ERASE_SETUP   = s_q.mode[`FPE_MC_ERASE_SETUP];
    assign PROG_VERIFY   = s_q.mode[`FPE_MC_PROG_CHECK];
    assign ERASE_VERIFY  = s_q.mode[`FPE_MC_ERASE_CHECK];
    assign PROG_MODE     = s_q.prog_mode;
    assign ERASE_MODE    = s_q.erase_mode;
    assign ERASE_AREA    = s_q.area;
    assign AREA_HIT      = s_q.area_hit;
    assign ERROR_PROTECT = s_q.fault;

    // Reserved mode bit reads zero
    a_mode_rsvd_zero: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R1]
        (CE && RD && ADDR == `FPE_OFS_MODE && s_q.gate) |=> (RDATA[7] == 1'b0))
        else $error("mode control bit 7 read as one");

    // Active modes only with unlock set
    a_unlock_gates_modes: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R2]
        (PROG_MODE || ERASE_MODE) |-> s_q.mode[`FPE_MC_UNLOCK])
        else $error("program or erase mode without unlock");

    // Locked write leaves every mode bit clear
    a_locked_write_clear: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R3]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && !WDATA[6])
        |=> (s_q.mode == 8'h00 && ERASE_AREA == 5'h00))
        else $error("locked write set a mode or area bit");

    // Erase setup follows an unlocked write
    a_erase_setup_set: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R4]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && WDATA[6])
        |=> (ERASE_SETUP == $past(WDATA[5])))
        else $error("erase setup did not follow write");

    // Program setup follows an unlocked write
    a_prog_setup_set: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R6]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && WDATA[6])
        |=> (PROG_SETUP == $past(WDATA[4])))
        else $error("program setup did not follow write");

    // Verify modes follow an unlocked write
    a_verify_modes_set: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R8] [R9]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && WDATA[6])
        |=> (ERASE_VERIFY == $past(WDATA[3]) && PROG_VERIFY == $past(WDATA[2])))
        else $error("verify mode did not follow write");

    // Erase mode needs setup and go
    a_erase_mode_cond: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R10]
        ERASE_MODE |-> (ERASE_SETUP && s_q.mode[`FPE_MC_EGO]))
        else $error("erase mode without setup and go");

    // Program mode needs setup and go
    a_prog_mode_cond: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R11]
        PROG_MODE |-> (PROG_SETUP && s_q.mode[`FPE_MC_PGO]))
        else $error("program mode without setup and go");

    // Fault sticks and blocks active modes
    a_fault_protects: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R13]
        ERROR_PROTECT |=> (ERROR_PROTECT && !PROG_MODE && !ERASE_MODE))
        else $error("error protection lost or mode active");

    // Fault status low bits read zero
    a_fault_rsvd_zero: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R14]
        (CE && RD && ADDR == `FPE_OFS_FAULT && s_q.gate) |=> (RDATA[6:0] == 7'h00))
        else $error("fault status reserved bits not zero");

    // Area select clear while locked
    a_area_locked_zero: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R15]
        !s_q.mode[`FPE_MC_UNLOCK] |-> (ERASE_AREA == 5'h00))
        else $error("area select set while locked");

    // Several area bits clear the register
    a_area_multi_clear: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R16]
        (CE && WR && ADDR == `FPE_OFS_AREA && s_q.gate && $countones(WDATA[4:0]) > 1)
        |=> (ERASE_AREA == 5'h00))
        else $error("multiple area bits not cleared");

    // Closed gate blocks mode writes
    a_gate_blocks_write: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R23]
        (CE && WR && ADDR == `FPE_OFS_MODE && !s_q.gate && !ARRAY_FAULT)
        |=> $stable(s_q.mode))
        else $error("write passed a closed access gate");

    // Read data falls back to zero without a read strobe
    a_rdata_idle_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        (CE && !RD) |=> (RDATA == 8'h00))
        else $error("read data not zero after idle cycle");

    // Closed gate reads back zero
    a_gate_closed_read: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R23]
        (CE && RD && !s_q.gate && ADDR != `FPE_OFS_GATE) |=> (RDATA == 8'h00))
        else $error("read passed a closed access gate");

    // Never more than one erase area selected
    a_area_one_hot: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R16]
        $countones(ERASE_AREA) <= 1)
        else $error("several erase areas selected");

    // Area write while locked leaves the select clear
    a_area_locked_write: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R3]
        (CE && WR && ADDR == `FPE_OFS_AREA && !s_q.mode[`FPE_MC_UNLOCK])
        |=> (ERASE_AREA == 5'h00))
        else $error("locked area write set a bit");

    // Single area bit written while unlocked sticks
    a_area_write_lands: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R16]
        (CE && WR && ADDR == `FPE_OFS_AREA && s_q.gate && s_q.mode[`FPE_MC_UNLOCK]
        && $countones(WDATA[4:0]) <= 1) |=> (ERASE_AREA == $past(WDATA[4:0])))
        else $error("single area write did not land");

    // Address in the large area hits while it is selected
    a_hit_large_area: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R18]
        (CE && !WR && ERASE_AREA[4] && ARRAY_ADDR >= `FPE_AREA4_BASE
        && ARRAY_ADDR <= `FPE_AREA4_LIMIT) |=> AREA_HIT)
        else $error("large area address missed");

    // Address in small area 3 hits while it is selected
    a_hit_area_three: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R19]
        (CE && !WR && ERASE_AREA[3] && ARRAY_ADDR >= `FPE_AREA3_BASE
        && ARRAY_ADDR <= `FPE_AREA3_LIMIT) |=> AREA_HIT)
        else $error("small area 3 address missed");

    // Address in small area 2 hits while it is selected
    a_hit_area_two: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R20]
        (CE && !WR && ERASE_AREA[2] && ARRAY_ADDR >= `FPE_AREA2_BASE
        && ARRAY_ADDR <= `FPE_AREA2_LIMIT) |=> AREA_HIT)
        else $error("small area 2 address missed");

    // Address in small area 1 hits while it is selected
    a_hit_area_one: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R21]
        (CE && !WR && ERASE_AREA[1] && ARRAY_ADDR >= `FPE_AREA1_BASE
        && ARRAY_ADDR <= `FPE_AREA1_LIMIT) |=> AREA_HIT)
        else $error("small area 1 address missed");

    // Address in small area 0 hits while it is selected
    a_hit_area_zero: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R22]
        (CE && !WR && ERASE_AREA[0] && ARRAY_ADDR <= `FPE_AREA0_LIMIT) |=> AREA_HIT)
        else $error("small area 0 address missed");

    // Fault during an active pulse sets error protection
    a_fault_sets: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R13]
        (CE && ARRAY_FAULT && (PROG_MODE || ERASE_MODE)) |=> ERROR_PROTECT)
        else $error("fault during pulse not latched");

    // Error protection only follows a fault in a pulse
    a_fault_needs_pulse: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R13]
        (CE && !ERROR_PROTECT && !(ARRAY_FAULT && (PROG_MODE || ERASE_MODE)))
        |=> !ERROR_PROTECT)
        else $error("error protection set without fault");

    // Unlocked erase setup and go enter erase mode
    a_erase_go_enters: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R10]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && WDATA[6] && WDATA[5] && WDATA[1]
        && !ERROR_PROTECT && !ARRAY_FAULT) |=> ERASE_MODE)
        else $error("erase mode not entered");

    // Unlocked program setup and go enter program mode
    a_prog_go_enters: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R11]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && WDATA[6] && WDATA[4] && WDATA[0]
        && !ERROR_PROTECT && !ARRAY_FAULT) |=> PROG_MODE)
        else $error("program mode not entered");

    // Clearing the erase go bit cancels erase mode
    a_erase_go_cancel: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R10]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && !WDATA[1]) |=> !ERASE_MODE)
        else $error("erase mode not cancelled");

    // Clearing the program go bit cancels program mode
    a_prog_go_cancel: assert property (@(posedge CORE_CLK) disable iff (RST)  // [R11]
        (CE && WR && ADDR == `FPE_OFS_MODE && s_q.gate && !WDATA[0]) |=> !PROG_MODE)
        else $error("program mode not cancelled");

    // Low clock enable freezes every register
    a_ce_freezes_state: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CE |=> $stable(s_q))
        else $error("state changed with clock enable low");

endmodule

`default_nettype wire

// *** tb/fpe_testbench.sv ***
// Self-checking testbench for the flash program and erase control block
`include "fpe_defines.svh"
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    logic        core_clk;
    logic        rst;
    logic        ce;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [14:0] array_addr;
    logic        array_fault;
    logic        prog_setup, erase_setup, prog_verify, erase_verify;
    logic        prog_mode, erase_mode, area_hit, error_protect;
    logic [4:0]  erase_area;
    int          fails;
    int          n_compared;
    logic [14:0] base [5];
    logic [14:0] limit [5];
    logic [14:0] miss;

    fpe_flash_ctrl dut (
        .CORE_CLK(core_clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .ARRAY_ADDR(array_addr),
        .ARRAY_FAULT(array_fault), .PROG_SETUP(prog_setup), .ERASE_SETUP(erase_setup),
        .PROG_VERIFY(prog_verify), .ERASE_VERIFY(erase_verify), .PROG_MODE(prog_mode),
        .ERASE_MODE(erase_mode), .ERASE_AREA(erase_area), .AREA_HIT(area_hit),
        .ERROR_PROTECT(error_protect)
    );

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data checked in the cycle after it
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask

    // Let registered outputs settle
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        rst = 1'b1; ce = 1'b1; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        array_addr = 15'h0000; array_fault = 1'b0; fails = 0; n_compared = 0;
        base  = '{`FPE_AREA0_BASE, `FPE_AREA1_BASE, `FPE_AREA2_BASE,
                  `FPE_AREA3_BASE, `FPE_AREA4_BASE};
        limit = '{`FPE_AREA0_LIMIT, `FPE_AREA1_LIMIT, `FPE_AREA2_LIMIT,
                  `FPE_AREA3_LIMIT, `FPE_AREA4_LIMIT};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // Gate closed: writes ignored, reads zero
        wr_reg(`FPE_OFS_MODE, 8'h70);
        rd_chk(`FPE_OFS_MODE, 8'h00);
        step(); `CHK(prog_setup, 1'b0)
        wr_reg(`FPE_OFS_GATE, 8'h80);
        // Locked writes and the reserved bit
        wr_reg(`FPE_OFS_MODE, 8'hBF);
        rd_chk(`FPE_OFS_MODE, 8'h00);
        wr_reg(`FPE_OFS_MODE, 8'hF0);
        rd_chk(`FPE_OFS_MODE, 8'h70);
        step(); `CHK(erase_setup, 1'b1)
        `CHK(prog_setup, 1'b1)
        wr_reg(`FPE_OFS_MODE, 8'h4C);
        step(); `CHK(erase_verify, 1'b1)
        `CHK(prog_verify, 1'b1)
        `CHK({erase_setup, prog_setup}, 2'b00)
        wr_reg(`FPE_OFS_MODE, 8'h40);
        step(); `CHK({erase_verify, prog_verify}, 2'b00)
        // Go bits without setup do not start a pulse
        wr_reg(`FPE_OFS_MODE, 8'h43);
        step(); `CHK({erase_mode, prog_mode}, 2'b00)
        // Setup then go, then cancel, for program and erase
        for (int k = 0; k < 2; k++) begin
            wr_reg(`FPE_OFS_MODE, k ? 8'h60 : 8'h50);
            wr_reg(`FPE_OFS_MODE, k ? 8'h62 : 8'h51);
            step(); `CHK({erase_mode, prog_mode}, k ? 2'b10 : 2'b01)
            wr_reg(`FPE_OFS_MODE, k ? 8'h60 : 8'h50);
            step(); `CHK({erase_mode, prog_mode}, 2'b00)
        end
        // Setup and go without unlock
        wr_reg(`FPE_OFS_MODE, 8'h00);
        wr_reg(`FPE_OFS_MODE, 8'h31);
        step(); `CHK(prog_mode, 1'b0)
        // Each erase area and its address range
        wr_reg(`FPE_OFS_MODE, 8'h40);
        for (int i = 0; i < 5; i++) begin
            miss = (i == 4) ? limit[3] : base[i + 1];
            wr_reg(`FPE_OFS_AREA, 8'h01 << i);
            rd_chk(`FPE_OFS_AREA, 8'h01 << i);
            `CHK(erase_area, 5'h01 << i)
            array_addr <= base[i];
            step(); step(); `CHK(area_hit, 1'b1)
            array_addr <= limit[i];
            step(); step(); `CHK(area_hit, 1'b1)
            array_addr <= miss;
            step(); step(); `CHK(area_hit, 1'b0)
        end
        // Several area bits at once clear the register
        wr_reg(`FPE_OFS_AREA, 8'h03);
        rd_chk(`FPE_OFS_AREA, 8'h00);
        wr_reg(`FPE_OFS_AREA, 8'h1F);
        rd_chk(`FPE_OFS_AREA, 8'h00);
        // Dropping unlock clears the area select, and locked area writes fail
        wr_reg(`FPE_OFS_AREA, 8'h04);
        wr_reg(`FPE_OFS_MODE, 8'h00);
        rd_chk(`FPE_OFS_AREA, 8'h00);
        `CHK(erase_area, 5'h00)
        wr_reg(`FPE_OFS_AREA, 8'h04);
        rd_chk(`FPE_OFS_AREA, 8'h00);
        rd_chk(4'h5, 8'h00);
        // Clock enable low freezes the registers
        wr_reg(`FPE_OFS_MODE, 8'h40);
        ce <= 1'b0;
        wr_reg(`FPE_OFS_MODE, 8'h00);
        ce <= 1'b1;
        rd_chk(`FPE_OFS_MODE, 8'h40);
        // Fault during erase forces error protection
        rd_chk(`FPE_OFS_FAULT, 8'h00);
        wr_reg(`FPE_OFS_MODE, 8'h60);
        wr_reg(`FPE_OFS_MODE, 8'h62);
        step();
        array_fault <= 1'b1;
        @(posedge core_clk);
        array_fault <= 1'b0;
        step(); `CHK(error_protect, 1'b1)
        `CHK(erase_mode, 1'b0)
        rd_chk(`FPE_OFS_FAULT, 8'h80);
        rd_chk(`FPE_OFS_GATE, 8'h80);
        rd_chk(`FPE_OFS_FAULT, 8'h80);
        wr_reg(`FPE_OFS_MODE, 8'h50);
        wr_reg(`FPE_OFS_MODE, 8'h51);
        step(); `CHK(prog_mode, 1'b0)
        // Second reset clears the fault
        rst <= 1'b1;
        step(); step();
        rst <= 1'b0;
        step(); `CHK(error_protect, 1'b0)
        close_out();
    end
endmodule

`default_nettype wire
